// ### hdl/adc_port_pkg.sv
// constants shared by the converter serial port and its testbench
// assumes a 40 MHz system clock and a 7-bit addressed two-wire bus
package adc_port_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLOCK_HZ = 40_000_000;
  localparam int REF_STARTUP_US = 12_000;  // reference settling after wake, 12 ms
  localparam int REF_STARTUP_CYCLES = REF_STARTUP_US * (CLOCK_HZ / 1_000_000);

  // ****************************************
  // bus addresses and frame shape
  // ****************************************
  localparam logic [6:0] ADDR_SELECT_HIGH = 7'h14;  // 0010100
  localparam logic [6:0] ADDR_SELECT_LOW = 7'h54;  // 1010100
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [3:0] CFG_LAST_BIT = 4'h3;
  localparam logic [4:0] MASTER_ACK_SLOT = 5'h08;
  localparam logic [4:0] READ_LAST_SLOT = 5'h10;
  localparam logic [4:0] READ_END_SLOT = 5'h11;

  // ****************************************
  // configuration word, first received bit highest
  // ****************************************
  localparam int CFG_EN_FIRST_POS = 3;
  localparam int CFG_EN_SECOND_POS = 2;
  localparam int CFG_RATE_POS = 1;
  localparam int CFG_POWERDOWN_POS = 0;
  localparam logic RATE_RESET = 1'b0;  // 250 sps
  localparam logic POWERDOWN_RESET = 1'b0;  // nap mode

  // ****************************************
  // result coding
  // ****************************************
  localparam logic signed [18:0] FULL_SCALE = 19'sh0FFFF;

  // ****************************************
  // port states, gray along idle-address-ack-read
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_READ = 3'h2,
    ST_WRITE = 3'h6,
    ST_IGNORE = 3'h7
  } port_state_e;

endpackage

// ### hdl/link_capture.sv
// shift register that samples the data line on each rising bus clock
// assumes the bus clock only moves during frames; holds data, no control
`timescale 1ns/1ps
module link_capture (
  // bus side
  input wire logic scl,
  input wire logic sda_in,
  // received bits, newest in bit 0
  output logic [7:0] rx_bits
);

  // ****************************************
  // capture
  // ****************************************
  // data only, so no reset: the framing lives in the system domain
  always_ff @(posedge scl) begin
    rx_bits <= {rx_bits[6:0], sda_in};
  end

endmodule

// ### hdl/adc_serial_port.sv
// two-wire slave port of a 16-bit converter: result read and config write
// assumes the converter core pulses conversion_done on this clock and
// that the bus clock stays below one tenth of the system clock
//
// Behaviour
// R1: answer only the address 0010100 or 1010100, chosen by the select pin.
// R2: a direction bit of 1 after the address requests a result read.
// R3: addressed while converting, leave the data line released for a NAK.
// R4: addressed after conversion completes, pull the data line low to acknowledge.
// R5: after a read acknowledge, shift 16 result bits, changing on falling clocks.
// R6: leave data transfer after all 16 bits or on a STOP, whichever first.
// R7: send the most significant bit first, down to the least significant.
// R8: differential code is integer part of 32767.5 times ratio plus 32767.5.
// R9: single-ended code is plain binary from zero to all ones.
// R10: the master writes configuration with a direction bit of 0.
// R11: the config word is four bits: enable one, enable two, rate, powerdown.
// R12: sample enable one on the first rising clock after acknowledge, then the rest.
// R13: accept new settings only when enable one is 1 and enable two 0.
// R14: rate select 0 (default) gives 250 sps, 1 gives 1 ksps.
// R15: powerdown 0 keeps reference on, only the converter sleeps after conversion.
// R16: powerdown 1 switches off reference and converter after the next conversion.
// R17: acknowledging a valid address powers reference and converter back up.
// R18: after wake the master waits about 12 ms or discards the first result.
// R19: when a read ends, a new conversion starts by itself.
// R20: reference takes about 12 ms to settle; earlier conversions are flagged invalid.
// R21: the code saturates at 65535 above full scale and 0 below.
// R22: STOP after an acknowledged read address drops the result, starts converting.
// R23: reset clears configuration, then a conversion begins on its own.
// R24: the master captures each result bit on the rising clock.
// R25: a wrong enable pattern leaves rate and powerdown unchanged.
// R26: a new rate applies from the next conversion that starts.
`timescale 1ns/1ps
module adc_serial_port
  import adc_port_pkg::*;
#(
  parameter bit DIFFERENTIAL = 1'b1,
  parameter int STARTUP_CYCLES = REF_STARTUP_CYCLES
) (
  // system
  input wire logic clock,
  input wire logic reset_n,
  // two-wire bus, data line open drain
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe_n,
  // strap
  input wire logic address_select_pin,
  // converter core
  input wire logic conversion_done,
  input wire logic signed [17:0] conversion_sample,
  output logic conversion_start,
  output logic converter_power,
  output logic reference_power,
  output logic rate_select,
  // status
  output logic reference_powerdown,
  output logic reference_ready,
  output logic result_invalid
);

  // ****************************************
  // declarations
  // ****************************************
  logic scl_meta, scl_s, scl_d;
  logic sda_meta, sda_s, sda_d;
  logic sel_meta, sel_s;
  logic [7:0] rx_bits;
  port_state_e state;
  logic [3:0] bit_cnt;
  logic [4:0] slot;
  logic rw;
  logic ack_due;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic addr_eval, addr_hit, ack_enter, cfg_eval, cfg_accept;
  logic read_end, read_abort;
  logic boot;
  logic converting;
  logic conv_bad;
  logic cfg_rate;
  logic [15:0] result_code;
  logic [19:0] startup_cnt;

  // ****************************************
  // functions
  // ****************************************
  // sample is in half-code steps so the .5 offset stays exact
  function automatic logic [15:0] to_code(input logic signed [17:0] s);
    logic signed [18:0] t;
    t = {s[17], s};
    if (DIFFERENTIAL) begin
      t = (t + FULL_SCALE) >>> 1;  // [R8]
    end
    if (t < 0) begin
      return 16'h0000;  // [R21]
    end else if (t > FULL_SCALE) begin
      return 16'hFFFF;  // [R21]
    end
    return t[15:0];  // [R9]
  endfunction

  // line level for a read slot: two master acknowledge slots stay released
  function automatic logic read_level(input logic [15:0] w, input logic [4:0] s);
    if (s == MASTER_ACK_SLOT || s >= READ_END_SLOT) begin
      return 1'b1;
    end else if (s < MASTER_ACK_SLOT) begin
      return w[4'(15 - s)];  // [R7]
    end
    return w[4'(16 - s)];  // [R7]
  endfunction

  // ****************************************
  // link capture in the bus clock domain
  // ****************************************
  link_capture u_link (
    .scl(scl),
    .sda_in(sda_in),
    .rx_bits(rx_bits)
  );

  // ****************************************
  // synchronisers and bus events
  // ****************************************
  // pins pass two flops; the third stage is only for edge detection
  always_ff @(posedge clock) begin
    scl_meta <= scl;
    scl_s <= scl_meta;
    scl_d <= scl_s;
    sda_meta <= sda_in;
    sda_s <= sda_meta;
    sda_d <= sda_s;
    sel_meta <= address_select_pin;
    sel_s <= sel_meta;
  end

  // rx_bits settled at least two clocks before scl_rise is seen here, and it
  // cannot move again until the next bus clock rise, so it is read safely
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // address and configuration decisions
  assign addr_eval = (state == ST_ADDR) && scl_rise && (bit_cnt == ADDR_LAST_BIT);
  assign addr_hit = rx_bits[7:1] == (sel_s ? ADDR_SELECT_HIGH : ADDR_SELECT_LOW);  // [R1]
  assign ack_enter = (state == ST_ADDR) && scl_fall && (bit_cnt == ADDR_BITS) && ack_due;
  assign cfg_eval = (state == ST_WRITE) && scl_rise && (bit_cnt == CFG_LAST_BIT);  // [R12]
  assign cfg_accept = cfg_eval && rx_bits[CFG_EN_FIRST_POS] && !rx_bits[CFG_EN_SECOND_POS];  // [R25]
  assign read_end = (state == ST_READ) && scl_fall && (slot == READ_LAST_SLOT);
  assign read_abort = stop_seen && ((state == ST_READ) || ((state == ST_ACK) && rw));

  // ****************************************
  // port state machine
  // ****************************************
  // stop beats start; both cancel whatever frame was in flight
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      slot <= 5'h00;
      rw <= 1'b0;
      ack_due <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop_seen) begin
      state <= ST_IDLE;  // [R6]
      sda_oe_n <= 1'b1;
    end else if (start_seen) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (addr_eval) begin
              rw <= rx_bits[0];  // [R2] [R10]
              ack_due <= addr_hit && !converting;  // [R3]
            end
          end else if (scl_fall && bit_cnt == ADDR_BITS) begin
            if (ack_due) begin
              state <= ST_ACK;
              sda_oe_n <= 1'b0;  // [R4]
            end else begin
              state <= ST_IGNORE;  // [R3]
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              state <= ST_READ;
              slot <= 5'h00;
              sda_oe_n <= read_level(result_code, 5'h00);  // [R5] [R7]
            end else begin
              state <= ST_WRITE;
              bit_cnt <= 4'h0;
              sda_oe_n <= 1'b1;
            end
          end
        end
        ST_READ: begin
          // each falling clock moves to the next bit for the master to take
          if (scl_fall) begin
            slot <= slot + 5'h01;
            sda_oe_n <= read_level(result_code, slot + 5'h01);  // [R5] [R24]
            if (read_end) begin
              state <= ST_IGNORE;  // [R6]
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (cfg_eval) begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  // only the 1-then-0 enable pattern programs; anything else is dropped
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cfg_rate <= RATE_RESET;  // [R23]
      reference_powerdown <= POWERDOWN_RESET;  // [R23]
    end else if (cfg_accept) begin
      cfg_rate <= rx_bits[CFG_RATE_POS];  // [R11] [R13]
      reference_powerdown <= rx_bits[CFG_POWERDOWN_POS];  // [R11] [R13]
    end
  end

  // ****************************************
  // conversion control
  // ****************************************
  // boot is held through reset so the first conversion starts on release
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      boot <= 1'b1;
      conversion_start <= 1'b0;
    end else begin
      boot <= 1'b0;
      conversion_start <= boot || read_end || read_abort;  // [R19] [R22] [R23]
    end
  end

  // busy flag gates the address acknowledge; a start outranks a done
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      converting <= 1'b0;
    end else if (conversion_start) begin
      converting <= 1'b1;
    end else if (conversion_done) begin
      converting <= 1'b0;
    end
  end

  // rate is latched at each start, so a write mid-conversion waits its turn
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rate_select <= RATE_RESET;
      conv_bad <= 1'b0;
    end else if (conversion_start) begin
      rate_select <= cfg_rate;  // [R14] [R26]
      conv_bad <= !reference_ready;  // [R20]
    end
  end

  // result and its validity tag move together on completion
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      result_code <= 16'h0000;
      result_invalid <= 1'b0;
    end else if (conversion_done) begin
      result_code <= to_code(conversion_sample);
      result_invalid <= conv_bad;  // [R20]
    end
  end

  // ****************************************
  // power control
  // ****************************************
  // wake on acknowledge wins over a finishing conversion in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      converter_power <= 1'b1;
    end else if (ack_enter || conversion_start) begin
      converter_power <= 1'b1;  // [R17]
    end else if (conversion_done) begin
      converter_power <= 1'b0;  // [R15] [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reference_power <= 1'b1;
    end else if (ack_enter) begin
      reference_power <= 1'b1;  // [R17]
    end else if (conversion_done && reference_powerdown) begin
      reference_power <= 1'b0;  // [R16]
    end
  end

  // settling timer restarts from zero every time the reference wakes
  always_ff @(posedge clock) begin
    if (!reset_n || !reference_power) begin
      startup_cnt <= 20'h00000;
      reference_ready <= 1'b0;
    end else if (!reference_ready) begin
      startup_cnt <= startup_cnt + 20'h00001;
      reference_ready <= startup_cnt == 20'(STARTUP_CYCLES - 1);  // [R20]
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_wrong_address;
    addr_eval && !addr_hit |-> ##1 !ack_due;
  endproperty
  a_wrong_address: assert property (p_wrong_address) else $error("foreign address armed"); // [R1]

  property p_nak_busy;
    addr_eval && converting |-> ##1 (sda_oe_n && state != ST_ACK) [*8];
  endproperty
  a_nak_busy: assert property (p_nak_busy) else $error("busy address acknowledged"); // [R3]

  property p_ack_low;
    state == ST_ACK |-> !sda_oe_n && reference_power && converter_power;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack slot not driven low"); // [R4]

  property p_msb_first;
    state == ST_ACK && rw && scl_fall |=> sda_oe_n == result_code[15];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb"); // [R7]

  property p_read_end_starts;
    read_end |=> conversion_start ##1 converting;
  endproperty
  a_read_end_starts: assert property (p_read_end_starts) else $error("no start after read"); // [R19]

  property p_abort_starts;
    read_abort |=> conversion_start && state == ST_IDLE;
  endproperty
  a_abort_starts: assert property (p_abort_starts) else $error("stop did not restart"); // [R22]

  property p_program;
    cfg_accept |=> reference_powerdown == $past(rx_bits[CFG_POWERDOWN_POS]);
  endproperty
  a_program: assert property (p_program) else $error("config not accepted"); // [R13]

  property p_keep_config;
    cfg_eval && !cfg_accept |=> $stable(cfg_rate) && $stable(reference_powerdown);
  endproperty
  a_keep_config: assert property (p_keep_config) else $error("bad pattern changed config"); // [R25]

  property p_sleep;
    conversion_done && reference_powerdown && !ack_enter |=> !reference_power && !converter_power;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not power down"); // [R16]

  property p_nap;
    conversion_done && !reference_powerdown && reference_power |=> reference_power;
  endproperty
  a_nap: assert property (p_nap) else $error("nap dropped the reference"); // [R15]

  property p_unsettled;
    conversion_start && !reference_ready |=> conv_bad;
  endproperty
  a_unsettled: assert property (p_unsettled) else $error("early conversion not flagged"); // [R20]

  property p_boot;
    $rose(boot == 1'b0) |-> conversion_start;
  endproperty
  a_boot: assert property (p_boot) else $error("no conversion after reset"); // [R23]

endmodule

// ### test/i2c_master_model.sv
// two-wire bus master stand-in: start, stop, bit, byte and word tasks
// assumes a pull-up on the data line; its clock steps on a 12 ns tick
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int QUARTER = 20
) (
  // bus side
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda
);
  // ********************
  // bus timing
  // ********************
  logic tick = 1'b0;
  logic [15:0] got_val;
  event got;

  // bus clock only moves inside the tasks, so it idles high between frames
  always #6 tick = ~tick;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  task automatic wait_q();
    repeat (QUARTER) @(posedge tick);
  endtask

  // one slot; data changes a quarter after the fall, never with clock high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n <= b;
    wait_q();
    scl <= 1'b1;
    wait_q();
    r = sda; // taken in the high phase, long after the device settled
    scl <= 1'b0;
    wait_q();
  endtask

  task automatic start();
    wait_q();
    sda_oe_n <= 1'b0;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask

  task automatic stop();
    sda_oe_n <= 1'b0;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_oe_n <= 1'b1;
    wait_q();
  endtask

  task automatic send_bits(input logic [7:0] v, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--) bit_io(v[i], r);
  endtask

  // address byte, then the device answer in the ninth slot
  task automatic send_byte(input logic [7:0] v);
    logic r;
    send_bits(v, 8);
    bit_io(1'b1, r);
    got_val = {15'h0, ~r};
    ->got;
  endtask

  // 16 result bits; our own ack slot after byte one stays released
  task automatic read_word();
    logic r;
    logic [15:0] w;
    for (int i = 0; i < 17; i++) begin
      bit_io(1'b1, r);
      if (i != 8) w = {w[14:0], r};
    end
    got_val = w;
    ->got;
  endtask
endmodule

// ### test/tb.sv
// self-checking bench for the converter two-wire port
// assumes the master stand-in; the converter core is modelled here
`timescale 1ns/1ps
module tb;
  import adc_port_pkg::*;
  // ********************
  // signals and stand-ins
  // ********************
  localparam int STARTUP = 50;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic address_select_pin = 1'b1;
  logic conversion_done = 1'b0;
  logic signed [17:0] conversion_sample = 18'sh0;
  logic scl, m_oe_n, sda_oe_n, sda;
  logic start, conv_pwr, ref_pwr, rate, pd, ready, invalid;
  logic converting = 1'b0;
  logic started = 1'b0;
  logic signed [17:0] next_sample = 18'sh0;
  logic [15:0] last_code = 16'h0;
  logic [15:0] exp_q[$];
  int conv_delay = 2000;
  int cnt = 0;
  int fails = 0;
  int checks = 0;

  // wired-AND data line with pull-up
  assign sda = m_oe_n & sda_oe_n;
  always #12.5 clock = ~clock;

  adc_serial_port #(.DIFFERENTIAL(1'b1), .STARTUP_CYCLES(STARTUP)) dut (
    .clock(clock), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_oe_n(sda_oe_n),
    .address_select_pin(address_select_pin), .conversion_done(conversion_done),
    .conversion_sample(conversion_sample), .conversion_start(start),
    .converter_power(conv_pwr), .reference_power(ref_pwr), .rate_select(rate),
    .reference_powerdown(pd), .reference_ready(ready), .result_invalid(invalid)
  );
  i2c_master_model master (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda));

  // half-code steps, clamped to the 16-bit range
  function automatic logic [15:0] code_of(input logic signed [17:0] s);
    int v;
    v = (int'(s) + 65535) >>> 1;
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return v[15:0];
  endfunction

  function automatic logic [6:0] own();
    return address_select_pin ? ADDR_SELECT_HIGH : ADDR_SELECT_LOW;
  endfunction

  // converter answers each start after conv_delay clocks; sample is
  // scrambled between answers so a stale value is never read by luck
  always @(posedge clock) begin
    conversion_done <= 1'b0;
    conversion_sample <= ~conversion_sample;
    if (start === 1'b1) begin
      converting <= 1'b1;
      started <= 1'b1;
      cnt <= conv_delay;
    end else if (converting && cnt == 0) begin
      converting <= 1'b0;
      conversion_done <= 1'b1;
      conversion_sample <= next_sample;
      last_code <= code_of(next_sample);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic addr(input logic [6:0] a, input logic rw, input logic ack);
    exp_q.push_back({15'h0, ack});
    master.start();
    master.send_byte({a, rw});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (converting !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
  endtask

  // full read; powers must be back on at the acknowledge
  task automatic read_frame();
    @(posedge clock) started <= 1'b0;
    addr(own(), 1'b1, 1'b1);
    check(conv_pwr, 1'b1);
    check(ref_pwr, 1'b1);
    exp_q.push_back(last_code);
    master.read_word();
    master.stop();
    check(started, 1'b1);
  endtask

  // ********************
  // tests
  // ********************
  initial begin
    logic [1:0] en;
    logic rs, p, exp_rate, exp_pd;
    logic signed [17:0] vals [5] = '{18'sh1FFFF, 18'sh20000, 18'sh0, 18'sh1, 18'sh3FFFF};
    void'($urandom(81456));
    exp_rate = RATE_RESET;
    exp_pd = POWERDOWN_RESET;
    next_sample = 18'sh1FFFF;
    repeat (16) @(negedge clock);
    check(sda_oe_n, 1'b1);
    check(rate, exp_rate);
    check(pd, exp_pd);
    @(posedge clock) reset_n <= 1'b1;
    addr(ADDR_SELECT_HIGH, 1'b1, 1'b0);
    master.stop();
    wait_idle();
    check(invalid, 1'b1);
    check(ready, 1'b1);
    check(conv_pwr, 1'b0);
    check(ref_pwr, 1'b1);
    conv_delay = 100;
    addr(ADDR_SELECT_LOW, 1'b1, 1'b0);
    master.stop();
    read_frame();
    // code boundaries then random samples, select pin toggling
    for (int i = 0; i < 11; i++) begin
      next_sample = (i < 5) ? vals[i] : 18'($urandom);
      @(posedge clock) address_select_pin <= i[0];
      wait_idle();
      check(invalid, 1'b0);
      read_frame();
    end
    // every enable pattern with random rate and powerdown bits
    for (int k = 0; k < 8; k++) begin
      en = k[1:0];
      rs = 1'($urandom);
      p = 1'($urandom);
      wait_idle();
      check(ref_pwr, !exp_pd);
      addr(own(), 1'b0, 1'b1);
      master.send_bits({en, rs, p, 4'h0}, 4);
      master.stop();
      if (en == 2'b10) exp_pd = p;
      check(pd, exp_pd);
      check(rate, exp_rate);
      if (en == 2'b10) exp_rate = rs;
      read_frame();
      check(rate, exp_rate);
    end
    // abort right after a read acknowledge; the pending code has its msb set so the
    // device leaves the line released in slot 0 and the master can raise a stop
    next_sample = 18'sh1FFFF;
    wait_idle();
    @(posedge clock) started <= 1'b0;
    addr(own(), 1'b1, 1'b1);
    master.stop();
    check(started, 1'b1);
    wait_idle();
    read_frame();
    end_sim();
  end

  // compares each bus answer with the oldest expectation
  always begin
    @(master.got);
    check(master.got_val, exp_q.pop_front());
  end

  // a hung bus or converter ends the run
  initial begin
    #2_000_000;
    fails++;
    end_sim();
  end
endmodule
